//--- design/tcm_cfg_params.svh
// constants for the tightly coupled memory configuration register bank
// assumes: included by bare name from the package and the design module
`ifndef TCM_CFG_PARAMS_SVH
`define TCM_CFG_PARAMS_SVH

// coprocessor register selectors
`define CR_ID_MAIN        4'h0
`define CR_ID_SUB         4'h0
`define CR_TCM_MAIN       4'h9
`define OP2_TCM_PRESENCE_STATUS    3'h2
`define OP2_DATA_REGION   3'h0
`define OP2_INSTR_REGION  3'h1

// field positions
`define STAT_DATA_BIT     16
`define STAT_INSTR_BIT    0
`define REG_ADDR_HI       31
`define REG_ADDR_LO       12
`define REG_SIZE_HI       5
`define REG_SIZE_LO       2
`define REG_ZERO_BIT      1
`define REG_ENABLE_BIT    0

// fixed size codes and reset values
`define SIZE_CODE_ABSENT  4'h0
`define SIZE_CODE_MIN     4'h3
`define SIZE_CODE_MAX     4'hB
`define INSTR_SIZE_CODE   4'h5
`define DATA_SIZE_CODE    4'h6
`define BASE_RESET        20'h00000
`define ENABLE_RESET      1'b0

// memory layout: byte offsets inside a region, ram page split
`define PAGE_ADDR_BIT     13
`define DATA_ROM_ADDR_BIT 14
`define RAM_WORDS         4096

`endif

//--- design/tcm_cfg_pkg.sv
// types shared by the tightly coupled memory configuration bank
// assumes: constants come from tcm_cfg_params.svh
`include "tcm_cfg_params.svh"
package tcm_cfg_pkg;
    // coprocessor register access from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  op2;
        logic [31:0] wdata;
    } cp_req_s;

    // one memory bus access (instruction or data side)
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_s;

    // region decode result
    typedef struct packed {
        logic        hit;
        logic        rom;
        logic        page;
        logic [10:0] word;
    } region_hit_s;
endpackage : tcm_cfg_pkg

//--- design/tcm_region_config_regs.sv
// tightly coupled memory region setup and status registers, plus the ram/rom behind them
// assumes: core issues coprocessor accesses as one-cycle valid requests on core_clk,
// instruction and data memory buses are on the same clock
//
// Summary of operation
// RL1 - status bit 16 high when data memory exists, else low.
// RL2 - status bit 0 high when instruction memory exists, else low.
// RL3 - region bits 31..12 are base address, shifted left by twelve.
// RL4 - size code in bits 5..2; 0 absent, 3..B mean 4KB to 1MB.
// RL5 - bit 1 of each region register always reads zero.
// RL6 - bit 0 written one enables the region, zero disables it.
// RL7 - instruction size field fixed at 5h, writes to it ignored.
// RL8 - data size field fixed at 6h, writes to it ignored.
// RL9 - software should program instruction base field with 00000h.
// RL10 - software should program data base field with 00008h.
// RL11 - data region backed by 16KB writable ram and 16KB rom.
// RL12 - region registers are c9; op2 0 data, op2 1 instruction.
// RL13 - 16KB ram split in two 8KB pages for parallel access.
// RL14 - status word read at c0, c0, op2 2.
// RL15 - software sets enable by read-modify-write and reads back.
`timescale 1ns/10ps
`include "tcm_cfg_params.svh"
module tcm_region_config_regs #(
    parameter bit          INSTR_PRESENT = 1'b1,
    parameter bit          DATA_PRESENT  = 1'b1,
    parameter int unsigned RAM_WORDS     = `RAM_WORDS,
    parameter logic [31:0] ROM_FILL      = 32'h0000_0000
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // coprocessor access
    input  wire tcm_cfg_pkg::cp_req_s  cp_req,
    output logic [31:0]                cp_rdata,
    output logic                       cp_rvalid,
    output logic                       cp_hit,
    // instruction memory bus
    input  wire tcm_cfg_pkg::mem_req_s ibus_req,
    output logic [31:0]                ibus_rdata,
    output logic                       ibus_ack,
    // data memory bus
    input  wire tcm_cfg_pkg::mem_req_s dbus_req,
    output logic [31:0]                dbus_rdata,
    output logic                       dbus_ack,
    // region state seen by the core
    output logic                       instr_region_on,
    output logic                       data_region_on
);
    import tcm_cfg_pkg::*;

    localparam int unsigned HALF = RAM_WORDS / 2;

    // region register state
    logic [19:0] instr_base_r;
    logic [19:0] instr_base_nxt;
    logic        instr_en_r;
    logic        instr_en_nxt;
    logic [19:0] data_base_r;
    logic [19:0] data_base_nxt;
    logic        data_en_r;
    logic        data_en_nxt;

    // coprocessor decode
    wire sel_c9      = cp_req.valid && cp_req.crn == `CR_TCM_MAIN;
    wire sel_data    = sel_c9 && cp_req.op2 == `OP2_DATA_REGION;       // [RL12]
    wire sel_instr   = sel_c9 && cp_req.op2 == `OP2_INSTR_REGION;      // [RL12]
    wire sel_status  = cp_req.valid && !cp_req.write && cp_req.crn == `CR_ID_MAIN
                       && cp_req.crm == `CR_ID_SUB && cp_req.op2 == `OP2_TCM_PRESENCE_STATUS; // [RL14]
    wire wr_data     = sel_data && cp_req.write && DATA_PRESENT;
    wire wr_instr    = sel_instr && cp_req.write && INSTR_PRESENT;
    wire any_hit     = sel_data || sel_instr || sel_status;

    // size fields are constants, write data never reaches them
    wire [3:0] instr_size = INSTR_PRESENT ? `INSTR_SIZE_CODE : `SIZE_CODE_ABSENT; // [RL7] [RL4]
    wire [3:0] data_size  = DATA_PRESENT ? `DATA_SIZE_CODE : `SIZE_CODE_ABSENT;   // [RL8] [RL4]

    function automatic logic [31:0] region_word(input logic [19:0] base,
                                                input logic [3:0]  size,
                                                input logic        en);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`REG_ADDR_HI:`REG_ADDR_LO] = base;                 // [RL3]
        w[`REG_SIZE_HI:`REG_SIZE_LO] = size;                 // [RL4]
        w[`REG_ZERO_BIT]             = 1'b0;                 // [RL5]
        w[`REG_ENABLE_BIT]           = en;                   // [RL6]
        return w;
    endfunction : region_word

    wire [31:0] status_word = ({31'h0, DATA_PRESENT} << `STAT_DATA_BIT)    // [RL1]
                            | ({31'h0, INSTR_PRESENT} << `STAT_INSTR_BIT); // [RL2]
    wire [31:0] instr_word  = region_word(instr_base_r, instr_size, instr_en_r);
    wire [31:0] data_word   = region_word(data_base_r, data_size, data_en_r);
    wire [31:0] rd_mux      = sel_status ? status_word :
                              sel_instr  ? instr_word  :
                              sel_data   ? data_word   : 32'h0000_0000;

    assign instr_base_nxt = wr_instr ? cp_req.wdata[`REG_ADDR_HI:`REG_ADDR_LO] : instr_base_r;
    assign instr_en_nxt   = wr_instr ? cp_req.wdata[`REG_ENABLE_BIT] : instr_en_r;  // [RL6]
    assign data_base_nxt  = wr_data ? cp_req.wdata[`REG_ADDR_HI:`REG_ADDR_LO] : data_base_r;
    assign data_en_nxt    = wr_data ? cp_req.wdata[`REG_ENABLE_BIT] : data_en_r;    // [RL6]

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            instr_base_r <= `BASE_RESET;
            instr_en_r   <= `ENABLE_RESET;
            data_base_r  <= `BASE_RESET;
            data_en_r    <= `ENABLE_RESET;
        end else begin
            instr_base_r <= instr_base_nxt;  // [RL3]
            instr_en_r   <= instr_en_nxt;
            data_base_r  <= data_base_nxt;   // [RL3]
            data_en_r    <= data_en_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cp_rdata  <= 32'h0000_0000;
            cp_rvalid <= 1'b0;
            cp_hit    <= 1'b0;
        end else begin
            cp_rdata  <= cp_req.write ? 32'h0000_0000 : rd_mux;
            cp_rvalid <= cp_req.valid && !cp_req.write;
            cp_hit    <= any_hit;
        end
    end

    // region decode: base address compared above the region size, 16KB instr, 32KB data
    wire [31:0] instr_base_addr = {instr_base_r, 12'h000};   // [RL3]
    wire [31:0] data_base_addr  = {data_base_r, 12'h000};    // [RL3]
    wire [31:0] ioff = ibus_req.addr - instr_base_addr;
    wire [31:0] doff = dbus_req.addr - data_base_addr;
    function automatic logic ioff_ok(input logic [31:0] off);
        return off[31:`DATA_ROM_ADDR_BIT + 1] == '0;
    endfunction : ioff_ok

    wire i_in  = INSTR_PRESENT && instr_en_r && ioff[31:`DATA_ROM_ADDR_BIT] == '0;
    wire d_in  = DATA_PRESENT && data_en_r && ioff_ok(doff);
    // data region: lower 16KB ram, upper 16KB rom
    wire d_rom = doff[`DATA_ROM_ADDR_BIT];                                       // [RL11]

    // two ram pages, each served once a cycle
    wire       i_page = ioff[`PAGE_ADDR_BIT];                                    // [RL13]
    wire       d_page = doff[`PAGE_ADDR_BIT];                                    // [RL13]
    wire [10:0] i_word = ioff[12:2];
    wire [10:0] d_word = doff[12:2];
    wire i_go  = ibus_req.valid && i_in;
    wire d_ram = dbus_req.valid && d_in && !d_rom;
    // same page collision: data side gets no ack in that cycle, instruction side wins
    wire clash = i_go && d_ram && (i_page == d_page);                             // [RL13]
    wire d_go  = dbus_req.valid && d_in && (d_rom || !clash);

    logic [31:0] page0_mem [HALF];
    logic [31:0] page1_mem [HALF];

    wire [31:0] i_rd = i_page ? page1_mem[i_word] : page0_mem[i_word];
    wire [31:0] d_rd = d_rom ? ROM_FILL :
                       (d_page ? page1_mem[d_word] : page0_mem[d_word]);

    // page writes: at most one port per page per cycle
    wire p0_i_we = i_go && ibus_req.write && !i_page;
    wire p1_i_we = i_go && ibus_req.write && i_page;
    wire p0_d_we = d_go && !d_rom && dbus_req.write && !d_page;                   // [RL11]
    wire p1_d_we = d_go && !d_rom && dbus_req.write && d_page;                    // [RL11]

    always_ff @(posedge core_clk) begin
        if (p0_i_we) begin
            page0_mem[i_word] <= ibus_req.wdata;
        end else if (p0_d_we) begin
            page0_mem[d_word] <= dbus_req.wdata;
        end
        if (p1_i_we) begin
            page1_mem[i_word] <= ibus_req.wdata;
        end else if (p1_d_we) begin
            page1_mem[d_word] <= dbus_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ibus_rdata      <= 32'h0000_0000;
            ibus_ack        <= 1'b0;
            dbus_rdata      <= 32'h0000_0000;
            dbus_ack        <= 1'b0;
            instr_region_on <= 1'b0;
            data_region_on  <= 1'b0;
        end else begin
            ibus_rdata      <= i_go ? i_rd : 32'h0000_0000;
            ibus_ack        <= i_go;
            dbus_rdata      <= d_go ? d_rd : 32'h0000_0000;
            dbus_ack        <= d_go;
            instr_region_on <= INSTR_PRESENT && instr_en_nxt;   // [RL6]
            data_region_on  <= DATA_PRESENT && data_en_nxt;     // [RL6]
        end
    end
endmodule : tcm_region_config_regs

//--- verif/tcm_cfg_checker.sv
// assertions for the tcm region register bank, bound to its top module
// assumes: one clock domain, synchronous active high reset
`timescale 1ns/10ps
module tcm_cfg_checker
    import tcm_cfg_pkg::*;
#(
    parameter bit INSTR_PRESENT = 1'b1,
    parameter bit DATA_PRESENT  = 1'b1
) (
    // clock and reset
    input wire logic             core_clk,
    input wire logic             sys_rst,
    // coprocessor access
    input wire tcm_cfg_pkg::cp_req_s  cp_req,
    input wire logic [31:0]      cp_rdata,
    input wire logic             cp_rvalid,
    input wire logic             cp_hit,
    // instruction bus and region state
    input wire tcm_cfg_pkg::mem_req_s ibus_req,
    input wire logic             ibus_ack,
    input wire logic             instr_region_on,
    input wire logic             data_region_on
);
    wire rd = cp_req.valid & ~cp_req.write;
    wire wr = cp_req.valid & cp_req.write;
    wire c9 = cp_req.crn == 4'h9;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_read_answer: assert property (rd |=> cp_rvalid)
        else $error("no read answer one cycle after a read");
    chk_bit1_zero: assert property (rd && c9 |=> cp_rdata[1] == 1'b0)
        else $error("region bit 1 read as one");
    chk_status_word: assert property (rd && cp_req.crn == 4'h0 && cp_req.crm == 4'h0
        && cp_req.op2 == 3'h2 |=> cp_hit && cp_rdata == {15'h0, DATA_PRESENT, 15'h0, INSTR_PRESENT})
        else $error("status word wrong");
    chk_instr_size: assert property (rd && c9 && cp_req.op2 == 3'h1 |=> cp_rdata[5:2] == 4'h5)
        else $error("instruction size code wrong");
    chk_data_size: assert property (rd && c9 && cp_req.op2 == 3'h0 |=> cp_rdata[5:2] == 4'h6)
        else $error("data size code wrong");
    chk_instr_enable: assert property (wr && c9 && cp_req.op2 == 3'h1
        |=> instr_region_on == $past(cp_req.wdata[0]))
        else $error("instruction enable not following write");
    chk_data_enable: assert property (wr && c9 && cp_req.op2 == 3'h0
        |=> data_region_on == $past(cp_req.wdata[0]))
        else $error("data enable not following write");
    chk_ack_cause: assert property (!ibus_req.valid |=> !ibus_ack)
        else $error("instruction ack without request");
endmodule : tcm_cfg_checker

bind tcm_region_config_regs tcm_cfg_checker #(
    .INSTR_PRESENT(INSTR_PRESENT), .DATA_PRESENT(DATA_PRESENT)) u_tcm_cfg_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .cp_req(cp_req), .cp_rdata(cp_rdata),
    .cp_rvalid(cp_rvalid), .cp_hit(cp_hit), .ibus_req(ibus_req), .ibus_ack(ibus_ack),
    .instr_region_on(instr_region_on), .data_region_on(data_region_on));

//--- verif/core_cp_model.sv
// behavioural core issuing coprocessor register accesses
// assumes: answers are registered on the taking edge and are ready just after it
`timescale 1ns/10ps
module core_cp_model
    import tcm_cfg_pkg::*;
(
    // clock
    input  wire logic            core_clk,
    // coprocessor access
    output tcm_cfg_pkg::cp_req_s cp_req,
    input  wire logic [31:0]     cp_rdata,
    input  wire logic            cp_hit
);
    initial cp_req = '0;
    // hold the request over the taking edge, take the answer in the next cycle
    task automatic access(input logic w, input logic [3:0] crn, crm, input logic [2:0] op2,
                          input logic [31:0] wd, output logic [32:0] r);
        @(posedge core_clk);
        #1 cp_req = '{1'b1, w, crn, crm, op2, wd};
        @(posedge core_clk);
        #1 r = {cp_hit, cp_rdata};
        cp_req = '{1'b0, 1'b0, ~crn, ~crm, ~op2, ~wd};
    endtask : access
endmodule : core_cp_model

//--- verif/tb_top.sv
// self-checking bench for the tcm region register bank
// assumes: core model drives coprocessor side, bench drives both memory buses
`timescale 1ns/10ps
module tb_top;
    import tcm_cfg_pkg::*;
    localparam logic [31:0] ROM_WORD = 32'hA5A5_5A5A;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    cp_req_s     cp_req;
    mem_req_s    ibus_req = '0;
    mem_req_s    dbus_req = '0;
    logic [31:0] cp_rdata, ibus_rdata, dbus_rdata;
    logic        cp_rvalid, cp_hit, ibus_ack, dbus_ack, instr_region_on, data_region_on;
    logic [32:0] r, ri, rd;
    int          mismatches = 0;
    int          n_checks = 0;
    always #5 core_clk = ~core_clk;
    tcm_region_config_regs #(.ROM_FILL(ROM_WORD)) u_tcm_region_config_regs (
        .core_clk(core_clk), .sys_rst(sys_rst), .cp_req(cp_req), .cp_rdata(cp_rdata),
        .cp_rvalid(cp_rvalid), .cp_hit(cp_hit), .ibus_req(ibus_req), .ibus_rdata(ibus_rdata),
        .ibus_ack(ibus_ack), .dbus_req(dbus_req), .dbus_rdata(dbus_rdata), .dbus_ack(dbus_ack),
        .instr_region_on(instr_region_on), .data_region_on(data_region_on));
    core_cp_model u_core_cp_model (.core_clk(core_clk), .cp_req(cp_req),
        .cp_rdata(cp_rdata), .cp_hit(cp_hit));
    task automatic chk(input string what, input logic [32:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cp(input logic w, input logic [3:0] crn, crm, input logic [2:0] op2,
                      input logic [31:0] wd);
        u_core_cp_model.access(w, crn, crm, op2, wd, r);
    endtask : cp
    task automatic mem(input logic iv, input logic [31:0] ia, input logic dv, dw,
                       input logic [31:0] da, wd);
        @(posedge core_clk);
        #1 ibus_req = '{iv, 1'b0, ia, 32'h0};
        dbus_req = '{dv, dw, da, wd};
        @(posedge core_clk);
        #1 ri = {ibus_ack, ibus_rdata};
        rd = {dbus_ack, dbus_rdata};
        ibus_req = '{1'b0, 1'b0, ~ia, 32'h0};
        dbus_req = '{1'b0, 1'b0, ~da, ~wd};
    endtask : mem
    task automatic t_status;
        cp(1'b0, 4'h0, 4'h0, 3'h2, 32'h0);
        chk("status word", 33'h1_0001_0001, r);
        chk("read valid", 33'h1, {32'h0, cp_rvalid});
        cp(1'b0, 4'h0, 4'h0, 3'h3, 32'h0);
        chk("unmapped read", 33'h0, r);
    endtask : t_status
    task automatic t_regions;
        cp(1'b1, 4'h9, 4'h1, 3'h1, 32'h0000_003F);
        chk("instr enable", 33'h1, {32'h0, instr_region_on});
        cp(1'b0, 4'h9, 4'h1, 3'h1, 32'h0);
        chk("instr setup", 33'h1_0000_0015, r);
        cp(1'b0, 4'h9, 4'h0, 3'h0, 32'h0);
        chk("data setup idle", 33'h1_0000_0018, r);
        cp(1'b1, 4'h9, 4'h0, 3'h0, 32'h8001 | (r[31:0] & 32'h0FFF));
        chk("data write hit", 33'h1_0000_0000, r);
        chk("data enable", 33'h1, {32'h0, data_region_on});
        cp(1'b0, 4'h9, 4'h0, 3'h0, 32'h0);
        chk("data setup", 33'h1_0000_8019, r);
    endtask : t_regions
    task automatic t_mem;
        mem(1'b0, 32'h0, 1'b1, 1'b1, 32'h8004, 32'h1234_5678);
        chk("ram write ack", 33'h1, {32'h0, rd[32]});
        mem(1'b1, 32'h2000, 1'b1, 1'b0, 32'h8004, 32'h0);
        chk("parallel data read", 33'h1_1234_5678, rd);
        chk("parallel instr ack", 33'h1, {32'h0, ri[32]});
        mem(1'b1, 32'h0004, 1'b1, 1'b0, 32'h8004, 32'h0);
        chk("same page instr", 33'h1_1234_5678, ri);
        chk("same page data", 33'h0, {32'h0, rd[32]});
        mem(1'b0, 32'h0, 1'b1, 1'b1, 32'hC000, 32'h0);
        mem(1'b0, 32'h0, 1'b1, 1'b0, 32'hC000, 32'h0);
        chk("rom read", {1'b1, ROM_WORD}, rd);
        cp(1'b1, 4'h9, 4'h0, 3'h1, 32'h0);
        mem(1'b1, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0);
        chk("disabled instr ack", 33'h0, {32'h0, ri[32]});
    endtask : t_mem
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (12) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        t_status;
        t_regions;
        t_mem;
        final_report;
    end
    // cuts a hang short
    initial begin
        #100000;
        mismatches++;
        final_report;
    end
endmodule : tb_top
